//--- hdl/tc_irq_pkg.sv
// Constants shared by the time-critical interrupt flow controller
package tc_irq_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PEND_LOW    = 8'h00;
  localparam logic [7:0] OFS_PEND_HIGH   = 8'h04;
  localparam logic [7:0] OFS_IER_LOW     = 8'h08;
  localparam logic [7:0] OFS_IER_HIGH    = 8'h0C;
  localparam logic [7:0] OFS_DBIER_LOW   = 8'h10;
  localparam logic [7:0] OFS_DBIER_HIGH  = 8'h14;
  localparam logic [7:0] OFS_CORE_STAT   = 8'h18;
  localparam logic [7:0] OFS_SAVED_STAT  = 8'h1C;
  localparam logic [7:0] OFS_EVT_STAT    = 8'h20;
  localparam logic [7:0] OFS_EVT_MASK    = 8'h24;
  localparam logic [7:0] OFS_ACK_VECTOR  = 8'h28;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_GLOBAL_IRQ_MASK      = 0;
  localparam int BIT_DEBUG_EVENT_MASK     = 1;
  localparam int BIT_EMU_REG_ACCESS_ALLOW = 2;
  localparam int BIT_RT_HALTED            = 3;
  localparam int BIT_EVT_ACK              = 0;
  localparam int BIT_EVT_RETURN           = 1;
  localparam int BIT_VEC_CRITICAL         = 8;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic RST_GLOBAL_IRQ_MASK      = 1'b1;
  localparam logic RST_DEBUG_EVENT_MASK     = 1'b1;
  localparam logic RST_EMU_REG_ACCESS_ALLOW = 1'b0;
  localparam logic [1:0] RST_EVT_MASK       = 2'h0;
  // ----------------------------------------------------------------
  // Acknowledge sequence states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DRAIN,
    ST_BRANCH,
    ST_SERVICE,
    ST_RESTORE
  } flow_state_t;
endpackage

//--- hdl/time_critical_irq_flow.sv
// Maskable interrupt flow with time-critical qualification and APB registers
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/10ps
module time_critical_irq_flow #(
  parameter int HALF_W = 16,
  parameter int ADDR_W = 24,
  parameter int STAT_W = 16
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [2*HALF_W-1:0] irq_req,
  input  wire logic                rt_emu_halted,
  input  wire logic                drain_done,
  input  wire logic                return_exec,
  input  wire logic [ADDR_W-1:0]   interrupted_addr,
  input  wire logic [STAT_W-1:0]   core_mode_status,
  output logic                     flush_younger,
  output logic                     branch_take,
  output logic [7:0]               branch_vector,
  output logic                     resume_take,
  output logic [ADDR_W-1:0]        resume_addr,
  output logic [STAT_W-1:0]        restored_status,
  output logic                     global_irq_mask,
  output logic                     debug_event_mask,
  output logic                     emu_reg_access_allow,
  output logic                     irq
);
  localparam int N = 2 * HALF_W;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [N-1:0]             pend_reg;
  logic [N-1:0]             ier_reg;
  logic [N-1:0]             dbier_reg;
  logic [N-1:0]             ack_clear;
  logic [N-1:0]             sw_clear;
  logic [N-1:0]             qual;
  logic [1:0]               evt_reg;
  logic [1:0]               evt_mask_reg;
  logic [1:0]               evt_set;
  logic [2:0]               saved_bits_reg;
  logic [ADDR_W-1:0]        saved_addr_reg;
  logic [STAT_W-1:0]        saved_stat_reg;
  logic [7:0]               vec_reg;
  logic [7:0]               vec_next;
  logic                     found;
  logic                     crit_reg;
  logic                     wr_en;
  logic                     rd_en;
  logic                     hit;
  logic [31:0]              rd_data;
  tc_irq_pkg::flow_state_t  state_reg;
  tc_irq_pkg::flow_state_t  state_next;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // One wait state: pready rises in the second access cycle
  assign wr_en = psel & penable & pready & pwrite;
  assign rd_en = psel & penable & ~pready;

  // Read mux, also flags unmapped addresses
  always_comb begin
    hit     = 1'b1;
    rd_data = 32'h0000_0000;
    case (paddr)
      tc_irq_pkg::OFS_PEND_LOW:   rd_data[HALF_W-1:0] = pend_reg[HALF_W-1:0];
      tc_irq_pkg::OFS_PEND_HIGH:  rd_data[HALF_W-1:0] = pend_reg[N-1:HALF_W];
      tc_irq_pkg::OFS_IER_LOW:    rd_data[HALF_W-1:0] = ier_reg[HALF_W-1:0];
      tc_irq_pkg::OFS_IER_HIGH:   rd_data[HALF_W-1:0] = ier_reg[N-1:HALF_W];
      tc_irq_pkg::OFS_DBIER_LOW:  rd_data[HALF_W-1:0] = dbier_reg[HALF_W-1:0];
      tc_irq_pkg::OFS_DBIER_HIGH: rd_data[HALF_W-1:0] = dbier_reg[N-1:HALF_W];
      tc_irq_pkg::OFS_CORE_STAT: begin
        rd_data[tc_irq_pkg::BIT_GLOBAL_IRQ_MASK]      = global_irq_mask;
        rd_data[tc_irq_pkg::BIT_DEBUG_EVENT_MASK]     = debug_event_mask;
        rd_data[tc_irq_pkg::BIT_EMU_REG_ACCESS_ALLOW] = emu_reg_access_allow;
        rd_data[tc_irq_pkg::BIT_RT_HALTED]            = rt_emu_halted;
      end
      tc_irq_pkg::OFS_SAVED_STAT: rd_data[2:0] = saved_bits_reg;
      tc_irq_pkg::OFS_EVT_STAT:   rd_data[1:0] = evt_reg;
      tc_irq_pkg::OFS_EVT_MASK:   rd_data[1:0] = evt_mask_reg;
      tc_irq_pkg::OFS_ACK_VECTOR: begin
        rd_data[7:0]                          = vec_reg;
        rd_data[tc_irq_pkg::BIT_VEC_CRITICAL] = crit_reg;   // Last entry was time-critical
      end
      default:                    hit = 1'b0;
    endcase
  end

  // Bus answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= rd_en;
      pslverr <= rd_en & ~hit;
      prdata  <= (rd_en & ~pwrite) ? rd_data : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Enable registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ier_reg   <= '0;
      dbier_reg <= '0;
    end else if (wr_en) begin
      case (paddr)
        tc_irq_pkg::OFS_IER_LOW:    ier_reg[HALF_W-1:0]   <= pwdata[HALF_W-1:0];
        tc_irq_pkg::OFS_IER_HIGH:   ier_reg[N-1:HALF_W]   <= pwdata[HALF_W-1:0];
        tc_irq_pkg::OFS_DBIER_LOW:  dbier_reg[HALF_W-1:0] <= pwdata[HALF_W-1:0];
        tc_irq_pkg::OFS_DBIER_HIGH: dbier_reg[N-1:HALF_W] <= pwdata[HALF_W-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pending flags
  // ----------------------------------------------------------------
  // Software clears by writing ones; a new request in that cycle wins
  always_comb begin
    sw_clear = '0;
    if (wr_en && paddr == tc_irq_pkg::OFS_PEND_LOW)
      sw_clear[HALF_W-1:0] = pwdata[HALF_W-1:0];
    if (wr_en && paddr == tc_irq_pkg::OFS_PEND_HIGH)
      sw_clear[N-1:HALF_W] = pwdata[HALF_W-1:0];
  end

  // Per-flag latch and qualification
  for (genvar i = 0; i < N; i++) begin : g_flag
    assign ack_clear[i] = (state_reg == tc_irq_pkg::ST_BRANCH) &&
                          (vec_reg == 8'(i));
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
        pend_reg[i] <= 1'b0;
      else if (irq_req[i])
        pend_reg[i] <= 1'b1;
      else if (ack_clear[i] || sw_clear[i])
        pend_reg[i] <= 1'b0;
    end
    // Halted: debug enable gates, global mask ignored
    assign qual[i] = pend_reg[i] && ier_reg[i] &&
                     (rt_emu_halted ? dbier_reg[i]
                                    : !global_irq_mask);
  end

  // Lowest numbered qualified source has priority
  always_comb begin
    found    = 1'b0;
    vec_next = 8'h00;
    for (int k = 0; k < N; k++) begin
      if (qual[k] && !found) begin
        found    = 1'b1;
        vec_next = 8'(k);
      end
    end
  end

  // ----------------------------------------------------------------
  // Acknowledge sequence
  // ----------------------------------------------------------------
  // Unqualified requests never leave idle, so the program runs on
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      tc_irq_pkg::ST_IDLE:    if (found) state_next = tc_irq_pkg::ST_DRAIN;
      tc_irq_pkg::ST_DRAIN:   if (drain_done) state_next = tc_irq_pkg::ST_BRANCH;
      tc_irq_pkg::ST_BRANCH:  state_next = tc_irq_pkg::ST_SERVICE;
      tc_irq_pkg::ST_SERVICE: if (return_exec) state_next = tc_irq_pkg::ST_RESTORE;
      tc_irq_pkg::ST_RESTORE: state_next = tc_irq_pkg::ST_IDLE;
      default:                state_next = tc_irq_pkg::ST_IDLE;
    endcase
  end

  // State and chosen vector; vector frozen once draining starts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= tc_irq_pkg::ST_IDLE;
      vec_reg   <= 8'h00;
      crit_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_reg == tc_irq_pkg::ST_IDLE && found) begin
        vec_reg  <= vec_next;
        crit_reg <= rt_emu_halted;
      end
    end
  end

  // Flush held while older instructions drain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      flush_younger <= 1'b0;
    else
      flush_younger <= (state_next == tc_irq_pkg::ST_DRAIN);
  end

  // Branch pulse carries the source index frozen at drain entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      branch_take   <= 1'b0;
      branch_vector <= 8'h00;
    end else begin
      branch_take   <= (state_reg == tc_irq_pkg::ST_BRANCH);
      branch_vector <= vec_reg;
    end
  end

  // Context save on branch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      saved_bits_reg <= 3'h0;
      saved_addr_reg <= '0;
      saved_stat_reg <= '0;
    end else if (state_reg == tc_irq_pkg::ST_BRANCH) begin
      saved_bits_reg <= {emu_reg_access_allow, debug_event_mask,
                         global_irq_mask};
      saved_addr_reg <= interrupted_addr;
      saved_stat_reg <= core_mode_status;
    end
  end

  // Restore pulse with return point and status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resume_take     <= 1'b0;
      resume_addr     <= '0;
      restored_status <= '0;
    end else begin
      resume_take     <= (state_reg == tc_irq_pkg::ST_RESTORE);
      resume_addr     <= saved_addr_reg;
      restored_status <= saved_stat_reg;
    end
  end

  // Core status bits; hardware forcing beats a software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_irq_mask      <= tc_irq_pkg::RST_GLOBAL_IRQ_MASK;
      debug_event_mask     <= tc_irq_pkg::RST_DEBUG_EVENT_MASK;
      emu_reg_access_allow <= tc_irq_pkg::RST_EMU_REG_ACCESS_ALLOW;
    end else if (state_reg == tc_irq_pkg::ST_BRANCH) begin
      global_irq_mask      <= 1'b1;
      debug_event_mask     <= 1'b1;
      emu_reg_access_allow <= 1'b0;
    end else if (state_reg == tc_irq_pkg::ST_RESTORE) begin
      global_irq_mask      <= saved_bits_reg[0];
      debug_event_mask     <= saved_bits_reg[1];
      emu_reg_access_allow <= saved_bits_reg[2];
    end else if (wr_en && paddr == tc_irq_pkg::OFS_CORE_STAT) begin
      global_irq_mask      <= pwdata[tc_irq_pkg::BIT_GLOBAL_IRQ_MASK];
      debug_event_mask     <= pwdata[tc_irq_pkg::BIT_DEBUG_EVENT_MASK];
      emu_reg_access_allow <= pwdata[tc_irq_pkg::BIT_EMU_REG_ACCESS_ALLOW];
    end
  end

  // ----------------------------------------------------------------
  // Event status and interrupt line
  // ----------------------------------------------------------------
  assign evt_set[tc_irq_pkg::BIT_EVT_ACK]    = (state_reg == tc_irq_pkg::ST_BRANCH);
  assign evt_set[tc_irq_pkg::BIT_EVT_RETURN] = (state_reg == tc_irq_pkg::ST_RESTORE);

  // Sticky, write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_reg      <= 2'h0;
      evt_mask_reg <= tc_irq_pkg::RST_EVT_MASK;
    end else begin
      if (wr_en && paddr == tc_irq_pkg::OFS_EVT_STAT)
        evt_reg <= evt_set | (evt_reg & ~pwdata[1:0]);
      else
        evt_reg <= evt_set | evt_reg;
      if (wr_en && paddr == tc_irq_pkg::OFS_EVT_MASK)
        evt_mask_reg <= pwdata[1:0];
    end
  end

  // Level output, one cycle behind the status bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(evt_reg & evt_mask_reg);
  end

endmodule // time_critical_irq_flow

//--- test/time_critical_irq_flow_monitor.sv
// Checker for the interrupt flow controller ports
`timescale 1ns/10ps
module time_critical_irq_flow_monitor #(
  parameter int HALF_W = 16,
  parameter int ADDR_W = 24
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [31:0]       prdata,
  input wire logic              flush_younger,
  input wire logic              drain_done,
  input wire logic              branch_take,
  input wire logic [7:0]        branch_vector,
  input wire logic              resume_take,
  input wire logic [ADDR_W-1:0] resume_addr,
  input wire logic              global_irq_mask,
  input wire logic              debug_event_mask,
  input wire logic              emu_reg_access_allow
);
  // ----------------------------------------------------------------
  // Properties, one clock domain
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_apb_wait; psel && penable && !pready |=> pready; endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("pready late");
  property p_apb_one; pready |=> !pready; endproperty
  a_apb_one: assert property (p_apb_one) else $error("pready held");
  property p_err_rdy; pslverr |-> pready; endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("pslverr alone");
  property p_rd_zero; !pready |-> prdata == 32'h0000_0000; endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("prdata not idle");
  property p_drain_hold; flush_younger && !drain_done |=> flush_younger; endproperty
  a_drain_hold: assert property (p_drain_hold) else $error("flush dropped early");
  property p_branch_after; $fell(flush_younger) |=> branch_take; endproperty
  a_branch_after: assert property (p_branch_after) else $error("no branch");
  property p_drained; branch_take |-> $past(flush_younger, 2); endproperty
  a_drained: assert property (p_drained) else $error("branch without drain");
  property p_fresh_ctx;
    branch_take |-> global_irq_mask && debug_event_mask && !emu_reg_access_allow;
  endproperty
  a_fresh_ctx: assert property (p_fresh_ctx) else $error("context not forced");
  property p_vec_range; branch_take |-> branch_vector < 2 * HALF_W; endproperty
  a_vec_range: assert property (p_vec_range) else $error("bad vector");
  property p_resume_stable; resume_take |-> $stable(resume_addr); endproperty
  a_resume_stable: assert property (p_resume_stable) else $error("resume moved");
endmodule // time_critical_irq_flow_monitor
bind time_critical_irq_flow time_critical_irq_flow_monitor #(
  .HALF_W(HALF_W), .ADDR_W(ADDR_W)) u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .flush_younger(flush_younger), .drain_done(drain_done), .branch_take(branch_take),
  .branch_vector(branch_vector), .resume_take(resume_take), .resume_addr(resume_addr),
  .global_irq_mask(global_irq_mask), .debug_event_mask(debug_event_mask),
  .emu_reg_access_allow(emu_reg_access_allow));

//--- test/core_model.sv
// Pipeline partner: drains on flush, returns after a delay
`timescale 1ns/10ps
module core_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        flush_younger,
  input  wire logic        branch_take,
  input  wire logic [3:0]  dly,
  output logic             drain_done,
  output logic             return_exec,
  output logic [23:0]      interrupted_addr,
  output logic [15:0]      core_mode_status
);
  logic [3:0] dcnt;
  logic [3:0] rcnt;
  logic       ret_pend;
  // Program point moves every cycle, so a late sample shows up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) interrupted_addr <= 24'h00_0000;
    else interrupted_addr <= interrupted_addr + 24'h00_0001;
  end
  assign core_mode_status = {interrupted_addr[7:0], ~interrupted_addr[7:0]};
  // Older instructions take dly cycles to finish
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) dcnt <= 4'h0;
    else if (!flush_younger) dcnt <= 4'h0;
    else if (dcnt != dly) dcnt <= dcnt + 4'h1;
  end
  assign drain_done = flush_younger && (dcnt == dly);
  // Handler ends dly+2 cycles after the branch pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      return_exec <= 1'b0;
      ret_pend    <= 1'b0;
      rcnt        <= 4'h0;
    end else begin
      return_exec <= 1'b0;
      if (branch_take) begin
        ret_pend <= 1'b1;
        rcnt     <= 4'h0;
      end else if (ret_pend) begin
        if (rcnt == dly) begin
          return_exec <= 1'b1;
          ret_pend    <= 1'b0;
        end else rcnt <= rcnt + 4'h1;
      end
    end
  end
endmodule // core_model

//--- test/time_critical_irq_flow_tb_top.sv
// Self-checking bench for the interrupt flow controller
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module time_critical_irq_flow_tb_top;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rt_emu_halted = 0;
  logic [7:0]  paddr = 0, branch_vector;
  logic [31:0] pwdata = 0, irq_req = 0, prdata, rd;
  logic [3:0]  dly = 0;
  logic        pready, pslverr, er, drain_done, return_exec, flush_younger, branch_take;
  logic        resume_take, gm, dm, ea, irq;
  logic [23:0] interrupted_addr, resume_addr;
  logic [15:0] core_mode_status, restored_status;
  int          errors = 0, cmp_count = 0, cyc = 0, seed = 55786, src, nf;
  int          pend_m = 0, ier_m = 0, dbier_m = 0;
  always #4 pclk = ~pclk;
  time_critical_irq_flow DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_req(irq_req), .rt_emu_halted(rt_emu_halted),
    .drain_done(drain_done), .return_exec(return_exec), .interrupted_addr(interrupted_addr),
    .core_mode_status(core_mode_status), .flush_younger(flush_younger),
    .branch_take(branch_take), .branch_vector(branch_vector), .resume_take(resume_take),
    .resume_addr(resume_addr), .restored_status(restored_status), .global_irq_mask(gm),
    .debug_event_mask(dm), .emu_reg_access_allow(ea), .irq(irq));
  core_model u_core (.pclk(pclk), .presetn(presetn), .flush_younger(flush_younger),
    .branch_take(branch_take), .dly(dly), .drain_done(drain_done), .return_exec(return_exec),
    .interrupted_addr(interrupted_addr), .core_mode_status(core_mode_status));
  // ----------------------------------------------------------------
  // Model, bus and flow tasks
  // ----------------------------------------------------------------
  // Lowest qualifying source; halted flow ignores the global mask
  function automatic int pick(int p, int e, int d, bit h, bit g);
    for (int i = 0; i < 32; i++) if (p[i] && e[i] && (h ? d[i] : !g)) return i;
    return -1;
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; er = pslverr; psel <= 0; penable <= 0;
  endtask
  // Long wait proving nothing is started
  task automatic quiet();
    nf = 0;
    repeat (20) begin @(posedge pclk); #1; if (flush_younger !== 1'b0) nf = 1; end
  endtask
  task automatic ack(input int v, input logic [2:0] rs);
    logic [23:0] a;
    while (branch_take !== 1'b1) begin @(posedge pclk); #1; end
    a = interrupted_addr - 24'h00_0001;
    `CHK(branch_vector, 8'(v))
    `CHK({ea, dm, gm}, 3'b011)
    pend_m &= ~(1 << v);
    while (resume_take !== 1'b1) begin @(posedge pclk); #1; end
    `CHK({resume_addr, restored_status}, {a, a[7:0], ~a[7:0]})
    `CHK({ea, dm, gm}, rs)
  endtask
  task automatic final_report();
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Run is a few hundred cycles; far margin before giving up
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin errors++; final_report(); end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk); #1;
    `CHK({gm, dm, ea, irq}, 4'b1100)
    apb(0, tc_irq_pkg::OFS_CORE_STAT, 0); `CHK(rd, 32'h0000_0003)
    apb(0, 8'h3C, 0); `CHK({er, rd}, {1'b1, 32'h0000_0000})
    // Ordinary flow: global mask set blocks, clearing it lets the flag through
    ier_m = 32'h20; apb(1, tc_irq_pkg::OFS_IER_LOW, 32'h0000_0020);
    apb(1, tc_irq_pkg::OFS_EVT_MASK, 32'h0000_0001);
    irq_req <= 32'h0000_0020; @(posedge pclk); irq_req <= 0; pend_m |= 32'h20;
    quiet(); `CHK(nf, 0)
    `CHK(pick(pend_m, ier_m, dbier_m, 0, 1), -1)
    apb(0, tc_irq_pkg::OFS_PEND_LOW, 0); `CHK(rd, 32'(pend_m))
    apb(1, tc_irq_pkg::OFS_CORE_STAT, 32'h0000_0004);
    ack(pick(pend_m, ier_m, dbier_m, 0, 0), 3'b100);
    apb(0, tc_irq_pkg::OFS_PEND_LOW, 0); `CHK(rd, 32'(pend_m))
    `CHK(irq, 1'b1)
    apb(0, tc_irq_pkg::OFS_EVT_STAT, 0); `CHK(rd, 32'h0000_0003)
    apb(1, tc_irq_pkg::OFS_EVT_STAT, 32'h0000_0003); apb(1, tc_irq_pkg::OFS_EVT_MASK, 0);
    repeat (2) @(posedge pclk); #1; `CHK(irq, 1'b0)
    // Halted flow: random high source, global mask set, debug enable missing
    @(posedge pclk);
    rt_emu_halted <= 1; src = 16 + ($random(seed) & 15); dly <= 4'($random(seed) & 7);
    apb(1, tc_irq_pkg::OFS_CORE_STAT, 32'h0000_0001); ier_m |= 1 << src;
    apb(1, tc_irq_pkg::OFS_IER_HIGH, 32'(ier_m >>> 16));
    irq_req <= (1 << src) | 32'h20; @(posedge pclk); irq_req <= 0; pend_m |= (1 << src) | 32'h20;
    quiet(); `CHK(nf, 0)
    apb(0, tc_irq_pkg::OFS_PEND_HIGH, 0); `CHK(rd, 32'((pend_m >>> 16) & 32'h0000_FFFF))
    dbier_m = 1 << src; apb(1, tc_irq_pkg::OFS_DBIER_HIGH, 32'(dbier_m >>> 16));
    ack(pick(pend_m, ier_m, dbier_m, 1, 1), 3'b001);
    quiet(); `CHK(nf, 0)
    // Readback of the last entry: vector with critical marker, saved and restored bits
    apb(0, tc_irq_pkg::OFS_ACK_VECTOR, 0); `CHK(rd, 32'h0000_0100 | 32'(src))
    apb(0, tc_irq_pkg::OFS_SAVED_STAT, 0); `CHK(rd, 32'h0000_0001)
    apb(0, tc_irq_pkg::OFS_CORE_STAT, 0); `CHK(rd, 32'h0000_0009)
    apb(0, tc_irq_pkg::OFS_PEND_LOW, 0); `CHK(rd, 32'(pend_m & 32'hFFFF))
    `CHK(irq, 1'b0)
    // Back to ordinary flow: source 5 now goes without a debug enable
    rt_emu_halted <= 0; apb(1, tc_irq_pkg::OFS_CORE_STAT, 0);
    ack(pick(pend_m, ier_m, dbier_m, 0, 0), 3'b000);
    // Enable missing with global mask clear: flag only latches, then software clears it
    @(posedge pclk); irq_req <= 32'h0000_0008; @(posedge pclk); irq_req <= 0; pend_m |= 8;
    quiet(); `CHK(nf, 0)
    apb(0, tc_irq_pkg::OFS_PEND_LOW, 0); `CHK(rd, 32'(pend_m))
    apb(1, tc_irq_pkg::OFS_PEND_LOW, 32'h0000_0008); pend_m &= ~8;
    apb(0, tc_irq_pkg::OFS_PEND_LOW, 0); `CHK(rd, 32'(pend_m))
    final_report();
  end
endmodule // time_critical_irq_flow_tb_top
